// *** shared/fcs_consts.svh ***
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// ----------------------------------------
// word indices, byte address is four times the index
// ----------------------------------------
`define FCS_IDX_W          16
`define FCS_CAL_FIRST_IDX  16'h2080
`define FCS_CAL_LAST_IDX   16'h208f
`define FCS_AMP_WORD_IDX   16'h2080
`define FCS_DESAT_WORD_IDX 16'h2081
`define FCS_REF_WORD_IDX   16'h2082
`define FCS_OT_WORD_IDX    16'h2083
`define FCS_TEMP_WORD_IDX  16'h2084
`define FCS_DEC_SEL_IDX    16'h2090
`define FCS_DEC_VAL_IDX    16'h2091
`define FCS_IDX_LSB        2

// ----------------------------------------
// word layout
// ----------------------------------------
`define FCS_WORD_W         14
`define FCS_NUM_WORDS      16
`define FCS_ERASED_WORD    14'h3fff
`define FCS_MASK_AMP       14'h007f
`define FCS_MASK_DESAT     14'h1f3f
`define FCS_MASK_REF       14'h3f0f
`define FCS_MASK_OT        14'h000f
`define FCS_MASK_TEMP      14'h03ff
`define FCS_MASK_NONE      14'h0000
`define FCS_AMP_MSB        6
`define FCS_AMP_LSB        0
`define FCS_DESAT_MSB      12
`define FCS_DESAT_LSB      8
`define FCS_AMP_ALT_ZERO   7'h20
`define FCS_DESAT_ALT_ZERO 5'h10
`define FCS_DEC_W          8
`define FCS_AMP_CODE_W     7
`define FCS_DESAT_CODE_W   5
`define FCS_SEL_AMP        1'h0
`define FCS_SEL_DESAT      1'h1

`endif

// *** shared/fcs_pkg.sv ***
package fcs_pkg;

  typedef enum logic [0:0] {
    FCS_ST_IDLE,
    FCS_ST_ACK
  } fcs_state_t;

  typedef struct packed {
    fcs_state_t               state;
    logic [15:0][13:0]        words;
    logic                     dec_sel;
    logic                     ack;
    logic                     err;
    logic [31:0]              dat;
  } fcs_regs_t;

endpackage

// *** hdl/fcs_sm_decode.sv ***
`include "fcs_consts.svh"

// sign-magnitude offset code to two's complement steps
module fcs_sm_decode #(
  parameter int          CODE_W   = 5,
  parameter int          OUT_W    = 8,
  parameter logic [CODE_W-1:0] ALT_ZERO = '0
) (
  // code in
  input  wire logic [CODE_W-1:0] code_i,
  // decoded value
  output logic signed [OUT_W-1:0] value_o
);

  initial begin
    if (OUT_W < CODE_W + 1) $error("fcs_sm_decode: OUT_W too small");
  end

  logic [OUT_W-1:0] mag;

  always_comb begin
    mag = '0;
    mag[CODE_W-2:0] = code_i[CODE_W-2:0];
    if (code_i == ALT_ZERO) begin
      value_o = '0;
    end else if (code_i[CODE_W-1]) begin
      value_o = -$signed(mag);
    end else begin
      value_o = $signed(mag);
    end
  end

endmodule

// *** hdl/fcs_cal_store.sv ***
// Decided for this implementation: register access over Wishbone.
`include "fcs_consts.svh"

// Function
// - calibration words sit read-only at indices 2080h to 208Fh and writes never change them.
// - each word is 14 bits with bit 13 on top and unused bits read zero.
// - word 2080h holds the seven-bit amplifier offset code in bits 6 to 0, bits 13 to 7 zero.
// - the amplifier offset code spans +-30 mV, 00h, 20h and 40h mean zero, the top bit is only polarity.
// - word 2081h holds the desaturation offset in bits 12 to 8 and resistor trim in bits 5 to 0.
// - the desaturation offset is sign-magnitude, 11111 is -30 mV, 01111 +30 mV, 10000 and 00000 zero.
// - word 2082h holds the reference buffer offset in bits 13 to 8 and band-gap trim in bits 3 to 0.
// - word 2083h holds the over-temperature threshold in bits 3 to 0, firmware copies it over.
// - word 2084h holds the temperature sensor reading taken at 30 degrees C.
// - the temperature reading sits in bits 9 to 0, bits 13 to 10 zero.
module fcs_cal_store #(
  parameter logic [13:0] AMP_WORD_INIT   = `FCS_ERASED_WORD,
  parameter logic [13:0] DESAT_WORD_INIT = `FCS_ERASED_WORD,
  parameter logic [13:0] REF_WORD_INIT   = `FCS_ERASED_WORD,
  parameter logic [13:0] OT_WORD_INIT    = `FCS_ERASED_WORD,
  parameter logic [13:0] TEMP_WORD_INIT  = `FCS_ERASED_WORD,
  parameter int          ADR_W           = 32
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  output logic                   err_o
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  initial begin
    if (ADR_W < `FCS_IDX_W + `FCS_IDX_LSB) $error("fcs_cal_store: ADR_W too small");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // field mask of each calibration slot, unused slots read zero
  function automatic logic [13:0] word_mask(input logic [3:0] slot);
    logic [13:0] m;
    m = `FCS_MASK_NONE;
    case (slot)
      4'h0: m = `FCS_MASK_AMP;
      4'h1: m = `FCS_MASK_DESAT;
      4'h2: m = `FCS_MASK_REF;
      4'h3: m = `FCS_MASK_OT;
      4'h4: m = `FCS_MASK_TEMP;
      default: m = `FCS_MASK_NONE;
    endcase
    return m;
  endfunction

  function automatic logic [3:0] slot_of(input logic [15:0] idx);
    logic [15:0] off;
    off = idx - `FCS_CAL_FIRST_IDX;
    return off[3:0];
  endfunction

  function automatic logic [13:0] init_of(input logic [3:0] slot);
    logic [13:0] v;
    v = `FCS_MASK_NONE;
    case (slot)
      4'h0: v = AMP_WORD_INIT;
      4'h1: v = DESAT_WORD_INIT;
      4'h2: v = REF_WORD_INIT;
      4'h3: v = OT_WORD_INIT;
      4'h4: v = TEMP_WORD_INIT;
      default: v = `FCS_MASK_NONE;
    endcase
    return v & word_mask(slot);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  fcs_pkg::fcs_regs_t r_q;
  fcs_pkg::fcs_regs_t r_d;

  logic [15:0]        idx;
  logic               adr_ok;
  logic               in_cal;
  logic               is_sel;
  logic               is_val;
  logic [13:0]        amp_word;
  logic [13:0]        desat_word;
  logic signed [7:0]  amp_dec;
  logic signed [7:0]  desat_dec;
  logic signed [7:0]  dec_val;

  assign idx    = adr_i[`FCS_IDX_LSB +: `FCS_IDX_W];
  assign adr_ok = (adr_i[`FCS_IDX_LSB-1:0] == '0) &&
                  ((adr_i >> (`FCS_IDX_W + `FCS_IDX_LSB)) == '0);
  assign in_cal = adr_ok && (idx >= `FCS_CAL_FIRST_IDX) && (idx <= `FCS_CAL_LAST_IDX);
  assign is_sel = adr_ok && (idx == `FCS_DEC_SEL_IDX);
  assign is_val = adr_ok && (idx == `FCS_DEC_VAL_IDX);

  assign amp_word   = r_q.words[slot_of(`FCS_AMP_WORD_IDX)];
  assign desat_word = r_q.words[slot_of(`FCS_DESAT_WORD_IDX)];

  // ----------------------------------------
  // offset code decoders
  // ----------------------------------------
  fcs_sm_decode #(
    .CODE_W   (`FCS_AMP_CODE_W),
    .OUT_W    (`FCS_DEC_W),
    .ALT_ZERO (`FCS_AMP_ALT_ZERO)
  ) u_amp_dec (
    .code_i  (amp_word[`FCS_AMP_MSB:`FCS_AMP_LSB]),
    .value_o (amp_dec)
  );

  fcs_sm_decode #(
    .CODE_W   (`FCS_DESAT_CODE_W),
    .OUT_W    (`FCS_DEC_W),
    .ALT_ZERO (`FCS_DESAT_ALT_ZERO)
  ) u_desat_dec (
    .code_i  (desat_word[`FCS_DESAT_MSB:`FCS_DESAT_LSB]),
    .value_o (desat_dec)
  );

  assign dec_val = (r_q.dec_sel == `FCS_SEL_DESAT) ? desat_dec : amp_dec;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_d     = r_q;
    r_d.ack = 1'b0;
    r_d.err = 1'b0;
    case (r_q.state)
      fcs_pkg::FCS_ST_IDLE: begin
        if (cyc_i && stb_i) begin
          r_d.state = fcs_pkg::FCS_ST_ACK;
          r_d.dat   = '0;
          if (in_cal) begin
            r_d.ack = 1'b1;
            if (!we_i) begin
              // words are only read, never disturbed
              r_d.dat[13:0] = r_q.words[slot_of(idx)];
            end
          end else if (is_sel) begin
            r_d.ack = 1'b1;
            if (we_i && sel_i[0]) begin
              r_d.dec_sel = dat_i[0];
            end
            if (!we_i) begin
              r_d.dat[0] = r_q.dec_sel;
            end
          end else if (is_val) begin
            r_d.ack = 1'b1;
            if (!we_i) begin
              r_d.dat = {{24{dec_val[7]}}, dec_val};
            end
          end else begin
            r_d.err = 1'b1;
          end
        end
      end
      fcs_pkg::FCS_ST_ACK: begin
        r_d.state = fcs_pkg::FCS_ST_IDLE;
      end
      default: begin
        r_d.state = fcs_pkg::FCS_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q.state   <= fcs_pkg::FCS_ST_IDLE;
      r_q.dec_sel <= `FCS_SEL_AMP;
      r_q.ack     <= 1'b0;
      r_q.err     <= 1'b0;
      r_q.dat     <= '0;
      for (int i = 0; i < `FCS_NUM_WORDS; i++) begin
        r_q.words[i] <= init_of(4'(i));
      end
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign dat_o = r_q.dat;
  assign ack_o = r_q.ack;
  assign err_o = r_q.err;

endmodule

// *** dv/fcs_cal_store_props.sv ***
module fcs_props #(
  parameter int ADR_W = 32
) (
  // clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // wishbone slave
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0]       sel_i,
  input wire logic [31:0]      dat_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic             err_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence rd_of(logic [15:0] idx);
    cyc_i && stb_i && !we_i && adr_i[17:2] == idx ##1 ack_o;
  endsequence

  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  err_pulse_a: assert property (err_o |=> !err_o) else $error("err held too long");
  single_answer_a: assert property (!(ack_o && err_o)) else $error("ack and err together");
  answer_time_a: assert property ($rose(cyc_i && stb_i) |=> ack_o || err_o) else $error("late answer");
  write_data_a: assert property (ack_o && $past(we_i) |-> dat_o == 32'h0) else $error("write data out");
  range_zero_a: assert property (ack_o && !$past(we_i) && $past(adr_i[17:6]) == 12'h208
    |-> dat_o[31:14] == 18'h0) else $error("word bits above 13");
  amp_word_a: assert property (rd_of(16'h2080) |-> dat_o[31:7] == 25'h0) else $error("amp word");
  desat_word_a: assert property (rd_of(16'h2081) |-> dat_o[13] == 1'b0 && dat_o[7:6] == 2'h0)
    else $error("desat word");
  ref_word_a: assert property (rd_of(16'h2082) |-> dat_o[7:4] == 4'h0) else $error("ref word");
  ot_word_a: assert property (rd_of(16'h2083) |-> dat_o[31:4] == 28'h0) else $error("ot word");
  temp_word_a: assert property (rd_of(16'h2084) |-> dat_o[31:10] == 22'h0) else $error("temp word");
endmodule

bind fcs_cal_store fcs_props #(.ADR_W(ADR_W)) u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .err_o(err_o));

// *** dv/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [31:0] adr_i = 32'h0;
  logic [31:0] dat_i = 32'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o;
  logic        err_o;
  logic        e;
  int          failures = 0;
  int          n_compared = 0;

  fcs_cal_store #(.AMP_WORD_INIT(14'h3fa0), .DESAT_WORD_INIT(14'h3fea), .REF_WORD_INIT(14'h2af5),
    .OT_WORD_INIT(14'h3ffa), .TEMP_WORD_INIT(14'h3e5b)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one classic cycle, waits for ack or err
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      finish_test();
    end else begin
      rd = dat_o;
      e = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(32'h8200, 32'h20);
    rd_chk(32'h8204, 32'h1f2a);
    rd_chk(32'h8208, 32'h2a05);
    rd_chk(32'h820c, 32'ha);
    rd_chk(32'h8210, 32'h25b);
    rd_chk(32'h8214, 32'h0);
    rd_chk(32'h823c, 32'h0);
    wb(1'b1, 32'h8200, 32'hffffffff);
    check({31'h0, e}, 32'h0);
    rd_chk(32'h8200, 32'h20);
    rd_chk(32'h8244, 32'h0);
    wb(1'b1, 32'h8240, 32'h1);
    rd_chk(32'h8240, 32'h1);
    rd_chk(32'h8244, 32'hfffffff1);
    rd_chk(32'h8204, 32'h1f2a);
    rd_chk(32'h8200, 32'h20);
    rd_chk(32'h8208, 32'h2a05);
    rd_chk(32'h8204, 32'h1f2a);
    wb(1'b0, 32'h9000, 32'h0);
    check({31'h0, e}, 32'h1);
    finish_test();
  end
endmodule
